// ### bench/erpm_ee_model.sv
`timescale 1ns/100ps
module erpm_ee_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ee_ready,
    input wire logic ee_restart,
    input wire logic [7:0] image [0:47],
    input wire logic [5:0] n_bytes,
    input wire logic [5:0] abort_at,
    input wire logic slow,
    output logic ee_valid,
    output logic [7:0] ee_data,
    output logic ee_abort
);
    // ==============================================================
    // image pointer, bytes handed out strictly in order
    logic [5:0] idx_reg;
    logic gap_reg;
    logic [7:0] last_reg;
    wire logic have = (idx_reg < n_bytes) && !gap_reg;
    wire logic take = ee_valid && ee_ready && !ee_abort;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_reg <= 6'h00;
            gap_reg <= 1'b0;
            last_reg <= 8'h00;
        end else if (ee_restart) begin
            idx_reg <= 6'h00;
            gap_reg <= 1'b0;
        end else if (take) begin
            idx_reg <= idx_reg + 6'h01;
            gap_reg <= slow;
            last_reg <= ee_data;
        end else begin
            gap_reg <= 1'b0;
        end
    end
    // idle data is inverted so a stale byte is never mistaken for a fresh one
    assign ee_valid = have;
    assign ee_data = have ? image[idx_reg] : ~last_reg;
    assign ee_abort = have && (idx_reg == abort_at);
endmodule

// ### bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import erpm_pkg::*;
    // ==============================================================
    // signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ee_valid, ee_abort, ee_ready, ee_restart, load_done;
    logic [7:0] ee_data;
    logic [7:0] img [0:47];
    logic [5:0] n_bytes, abort_at;
    int n_errors = 0;
    int n_tests = 0;
    localparam logic [7:0] ADDRS [0:4] = '{ADDR_CMD, ADDR_SSID, ADDR_LEGACY, ADDR_SYSCTL, ADDR_DEVCTL};
    localparam logic [31:0] RSTS [0:4] = '{RST_CMD, RST_SSID, RST_LEGACY, RST_SYSCTL, RST_DEVCTL};

    erpm_loader i_erpm_loader (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ee_valid(ee_valid), .ee_data(ee_data), .ee_abort(ee_abort),
        .ee_ready(ee_ready), .ee_restart(ee_restart), .load_done(load_done));
    erpm_ee_model i_erpm_ee_model (.pclk(pclk), .presetn(presetn), .ee_ready(ee_ready),
        .ee_restart(ee_restart), .image(img), .n_bytes(n_bytes), .abort_at(abort_at), .slow(slow),
        .ee_valid(ee_valid), .ee_data(ee_data), .ee_abort(ee_abort));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ==============================================================
    // access and compare tasks
    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk32(name, exp, rd);
        chk1(name, 1'b0, err);
    endtask
    // waits on the loader's own completion flag, bounded so a hang is caught here
    task automatic wait_done(input logic val);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (load_done !== val && n < 500);
        chk1("load_done", val, load_done);
    endtask
    task automatic reload();
        apb(1'b1, ADDR_LDCTL, 32'h00000001);
        wait_done(1'b0);
        chk1("ee_restart", 1'b1, ee_restart);
        wait_done(1'b1);
        chk1("ee_restart", 1'b0, ee_restart);
        repeat (3) @(posedge pclk);
    endtask
    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        stop_test();
    end

    // ==============================================================
    // test sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        n_bytes = 6'h00;
        abort_at = 6'h3F;
        slow = 1'b0;
        for (int i = 0; i < 48; i++) img[i] = 8'h5A ^ 8'(i);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rdchk("reset", ADDRS[i], RSTS[i]);
        chk1("ee_ready", 1'b1, ee_ready);
        img[0] <= FUNC_CARD;
        img[1] <= 8'h22;
        img[EE_CMD] <= 8'hFF;
        {img[4], img[5], img[6], img[7]} <= {8'h11, 8'h22, 8'h33, 8'h44};
        {img[8], img[9], img[10], img[11]} <= {8'hFF, 8'h56, 8'h78, 8'h9A};
        img[EE_SYSCTL] <= 8'hFF;
        img[EE_DEVCTL] <= 8'hFE;
        n_bytes <= 6'h24;
        wait_done(1'b1);
        repeat (3) @(posedge pclk);
        rdchk("cmd", ADDR_CMD, 32'h00000167);
        rdchk("ssid", ADDR_SSID, 32'h44332211);
        rdchk("legacy", ADDR_LEGACY, 32'h9A7856FE);
        rdchk("sysctl", ADDR_SYSCTL, 32'h0000007F);
        rdchk("devctl", ADDR_DEVCTL, 32'h007E0000);
        rdchk("status", ADDR_LDSTAT, 32'h00000002);
        chk1("ee_ready", 1'b0, ee_ready);
        apb(1'b1, ADDR_SYSCTL, 32'hFFFFFFFF);
        rdchk("sysctl sw", ADDR_SYSCTL, 32'h0000007F);
        apb(1'b1, ADDR_LDSTAT, 32'h00000000);
        rdchk("status ro", ADDR_LDSTAT, 32'h00000002);
        apb(1'b0, 8'h08, 32'h00000000);
        chk1("unmapped err", 1'b1, err);
        chk32("unmapped data", 32'h00000000, rd);
        // short block, slow source: byte 17h lies past the length and must not land
        img[1] <= 8'h0B;
        img[EE_CMD] <= 8'h98;
        {img[4], img[5], img[6], img[7]} <= {8'hA1, 8'hB2, 8'hC3, 8'hD4};
        {img[8], img[9], img[10], img[11]} <= {8'h01, 8'h00, 8'h00, 8'h00};
        img[EE_SYSCTL] <= 8'h80;
        img[EE_DEVCTL] <= 8'h00;
        n_bytes <= 6'h18;
        slow <= 1'b1;
        reload();
        rdchk("cmd", ADDR_CMD, 32'h00000100);
        rdchk("ssid", ADDR_SSID, 32'hD4C3B2A1);
        rdchk("legacy", ADDR_LEGACY, 32'h00000000);
        rdchk("sysctl", ADDR_SYSCTL, 32'h00000000);
        rdchk("devctl", ADDR_DEVCTL, 32'h007E0000);
        img[0] <= 8'h01;
        img[EE_CMD] <= 8'hFF;
        reload();
        rdchk("status other", ADDR_LDSTAT, 32'h0000000A);
        rdchk("cmd other", ADDR_CMD, 32'h00000100);
        img[0] <= FUNC_CARD;
        img[1] <= 8'h00;
        reload();
        rdchk("status empty", ADDR_LDSTAT, 32'h00000002);
        rdchk("cmd empty", ADDR_CMD, 32'h00000100);
        img[1] <= 8'h22;
        abort_at <= 6'h03;
        slow <= 1'b0;
        reload();
        rdchk("status abort", ADDR_LDSTAT, 32'h00000006);
        rdchk("cmd abort", ADDR_CMD, 32'h00000167);
        stop_test();
    end
endmodule

// ### hw/erpm_cfg_regs.sv
`timescale 1ns/100ps
module erpm_cfg_regs
    import erpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    erpm_cfg_if.regs cfg
);

    logic [31:0] cmd_reg, ssid_reg, legacy_reg, sysctl_reg, devctl_reg, rd_data_reg;
    logic [31:0] cmd_next, ssid_next, legacy_next, sysctl_next, devctl_next, rd_next;

    // ==============================================================
    // update: the loader wins over a software write in the same cycle
    function automatic logic [31:0] upd(input logic [31:0] old, input logic [7:0] a, input logic [31:0] m);
        if (cfg.ld_we && cfg.ld_addr == a) begin
            upd = erpm_merge(old, cfg.ld_data, cfg.ld_mask & m);
        end else if (cfg.sw_we && cfg.sw_addr == a) begin
            upd = erpm_merge(old, cfg.sw_data, m);
        end else begin
            upd = old;
        end
    endfunction

    // a process rather than assigns: upd reads the bus strobes that are not its arguments
    always_comb begin
        cmd_next = upd(cmd_reg, ADDR_CMD, MASK_CMD);
        ssid_next = upd(ssid_reg, ADDR_SSID, MASK_SSID);
        legacy_next = upd(legacy_reg, ADDR_LEGACY, MASK_LEGACY);
        sysctl_next = upd(sysctl_reg, ADDR_SYSCTL, MASK_SYSCTL);
        devctl_next = upd(devctl_reg, ADDR_DEVCTL, MASK_DEVCTL);
    end

    assign rd_next = (cfg.rd_addr == ADDR_CMD) ? cmd_reg :
                     (cfg.rd_addr == ADDR_SSID) ? ssid_reg :
                     (cfg.rd_addr == ADDR_LEGACY) ? legacy_reg :
                     (cfg.rd_addr == ADDR_SYSCTL) ? sysctl_reg :
                     (cfg.rd_addr == ADDR_DEVCTL) ? devctl_reg :
                     (cfg.rd_addr == ADDR_LDSTAT) ? {28'h0000000, cfg.status} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= RST_CMD;
            ssid_reg <= RST_SSID;
            legacy_reg <= RST_LEGACY;
            sysctl_reg <= RST_SYSCTL;
            devctl_reg <= RST_DEVCTL;
            rd_data_reg <= 32'h00000000;
        end else begin
            cmd_reg <= cmd_next;
            ssid_reg <= ssid_next;
            legacy_reg <= legacy_next;
            sysctl_reg <= sysctl_next;
            devctl_reg <= devctl_next;
            rd_data_reg <= rd_next;
        end
    end

    assign cfg.rd_data = rd_data_reg;

endmodule

// ### hw/erpm_loader.sv
`timescale 1ns/100ps
// Overview of operation
// - The first image byte selects the function, and only a value of zero starts the card-socket block.
// - Image byte 02h feeds command bit 8 from its bit 7, bits 6..5 and 2..0 straight across, and bits 4..3 are dropped.
// - Image bytes 04h..07h fill configuration bytes 40h..43h low byte first, vendor then subsystem identifier.
// - Image bytes 08h..0Bh fill the legacy base address at 44h..47h, leaving bit 0 of the lowest byte alone.
// - Image byte 0Ch fills bits 6..0 of system control byte 80h while bit 7 keeps its reset value.
module erpm_loader
    import erpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ee_valid,
    input wire logic [7:0] ee_data,
    input wire logic ee_abort,
    output logic ee_ready,
    output logic ee_restart,
    output logic load_done
);

    erpm_cfg_if cfg_bus ();

    erpm_cfg_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_bus.regs)
    );

    // ==============================================================
    // image offset to register write
    function automatic erpm_wr_t map_byte(input logic [7:0] off, input logic [7:0] d);
        erpm_wr_t w;
        logic [4:0] sh;
        w = '0;
        sh = {off[1:0], 3'b000};
        if (off == EE_CMD) begin
            w.hit = 1'b1;
            w.addr = ADDR_CMD;
            w.data = {23'h000000, d[7], 1'b0, d[6:5], 2'b00, d[2:0]};
            w.mask = MASK_CMD;
        end else if (off >= EE_SSID_LO && off <= EE_SSID_HI) begin
            w.hit = 1'b1;
            w.addr = ADDR_SSID;
            w.data = {24'h000000, d} << sh;
            w.mask = 32'h000000FF << sh;
        end else if (off >= EE_LEG_LO && off <= EE_LEG_HI) begin
            w.hit = 1'b1;
            w.addr = ADDR_LEGACY;
            w.data = {24'h000000, d} << sh;
            w.mask = (32'h000000FF << sh) & MASK_LEGACY;
        end else if (off == EE_SYSCTL) begin
            w.hit = 1'b1;
            w.addr = ADDR_SYSCTL;
            w.data = {24'h000000, d};
            w.mask = MASK_SYSCTL;
        end else if (off == EE_DEVCTL) begin
            // bit 0 of the image byte is never copied, so a stray one is harmless
            w.hit = 1'b1;
            w.addr = ADDR_DEVCTL;
            w.data = {8'h00, d, 16'h0000};
            w.mask = MASK_DEVCTL;
        end
        map_byte = w;
    endfunction

    // ==============================================================
    // apb decode
    erpm_state_t state_reg, state_next;
    logic [7:0] off_reg, off_next, left_reg, left_next;
    logic abort_reg, abort_next, otherfn_reg, otherfn_next;
    logic ld_we_reg, ld_we_next;
    logic [7:0] ld_addr_reg;
    logic [31:0] ld_data_reg, ld_mask_reg;
    erpm_wr_t wr;

    wire apb_wr = psel && penable && pwrite;
    wire mapped = (paddr == ADDR_CMD) || (paddr == ADDR_SSID) || (paddr == ADDR_LEGACY) ||
                  (paddr == ADDR_SYSCTL) || (paddr == ADDR_DEVCTL) || (paddr == ADDR_LDCTL) ||
                  (paddr == ADDR_LDSTAT);
    wire reload = apb_wr && paddr == ADDR_LDCTL && pwdata[CTL_RELOAD_BIT];
    wire active = (state_reg == S_IND) || (state_reg == S_LEN) || (state_reg == S_DATA);
    wire take = ee_valid && active && !ee_abort;
    wire data_take = take && state_reg == S_DATA;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = cfg_bus.rd_data;
    assign cfg_bus.rd_addr = paddr;
    assign cfg_bus.sw_we = apb_wr && mapped && paddr != ADDR_LDCTL;
    assign cfg_bus.sw_addr = paddr;
    assign cfg_bus.sw_data = pwdata;

    // ==============================================================
    // loader sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IND: begin
                if (ee_abort) begin
                    state_next = S_DONE;
                end else if (take) begin
                    state_next = (ee_data == FUNC_CARD) ? S_LEN : S_DONE;
                end
            end
            S_LEN: begin
                if (ee_abort) begin
                    state_next = S_DONE;
                end else if (take) begin
                    state_next = (ee_data == 8'h00) ? S_DONE : S_DATA;
                end
            end
            S_DATA: begin
                if (ee_abort || (take && left_reg == 8'h01)) begin
                    state_next = S_DONE;
                end
            end
            S_DONE: state_next = S_DONE;
            S_RESTART: state_next = S_IND;
            default: state_next = S_IND;
        endcase
        if (reload) begin
            state_next = S_RESTART;
        end
    end

    assign off_next = (state_reg == S_RESTART) ? EE_START : (take ? off_reg + 8'h01 : off_reg);
    assign left_next = (take && state_reg == S_LEN) ? ee_data : (data_take ? left_reg - 8'h01 : left_reg);
    // an abort in the same cycle as a reload shows only until the restart state clears it
    assign abort_next = (abort_reg && !reload && state_reg != S_RESTART) || (active && ee_abort);
    assign otherfn_next = (otherfn_reg && !reload && state_reg != S_RESTART) ||
                          (take && state_reg == S_IND && ee_data != FUNC_CARD);
    assign wr = map_byte(off_reg, ee_data);
    assign ld_we_next = data_take && wr.hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IND;
            off_reg <= EE_START;
            left_reg <= 8'h00;
            abort_reg <= 1'b0;
            otherfn_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            off_reg <= off_next;
            left_reg <= left_next;
            abort_reg <= abort_next;
            otherfn_reg <= otherfn_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_we_reg <= 1'b0;
            ld_addr_reg <= 8'h00;
            ld_data_reg <= 32'h00000000;
            ld_mask_reg <= 32'h00000000;
        end else begin
            ld_we_reg <= ld_we_next;
            ld_addr_reg <= wr.addr;
            ld_data_reg <= wr.data;
            ld_mask_reg <= wr.mask;
        end
    end

    assign cfg_bus.ld_we = ld_we_reg;
    assign cfg_bus.ld_addr = ld_addr_reg;
    assign cfg_bus.ld_data = ld_data_reg;
    assign cfg_bus.ld_mask = ld_mask_reg;
    assign cfg_bus.status = {otherfn_reg, abort_reg, state_reg == S_DONE, !(state_reg == S_DONE)};
    assign ee_ready = active;
    assign ee_restart = state_reg == S_RESTART;
    assign load_done = state_reg == S_DONE;

    // ==============================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ind_select_a: assert property (take && state_reg == S_IND && ee_data != FUNC_CARD && !reload
        |=> state_reg == S_DONE && otherfn_reg && !ld_we_reg) else $error("non-zero indicator not refused");

    cmd_remap_a: assert property (data_take && off_reg == EE_CMD
        |=> ld_we_reg && ld_addr_reg == ADDR_CMD && ld_mask_reg == 32'h00000167 &&
            ld_data_reg[8] == $past(ee_data[7]) && ld_data_reg[6:5] == $past(ee_data[6:5]) &&
            ld_data_reg[2:0] == $past(ee_data[2:0])) else $error("command byte remap wrong");

    ssid_lane_a: assert property (data_take && off_reg >= EE_SSID_LO && off_reg <= EE_SSID_HI
        |=> ld_we_reg && ld_addr_reg == ADDR_SSID &&
            ld_data_reg[{$past(off_reg[1:0]), 3'b000} +: 8] == $past(ee_data)) else $error("subsystem byte lane wrong");

    legacy_bit0_a: assert property (data_take && off_reg == EE_LEG_LO
        |=> ld_we_reg && ld_addr_reg == ADDR_LEGACY && ld_mask_reg == 32'h000000FE) else $error("legacy bit 0 written");

    sysctl_mask_a: assert property (data_take && off_reg == EE_SYSCTL
        |=> ld_we_reg && ld_addr_reg == ADDR_SYSCTL && ld_mask_reg == 32'h0000007F) else $error("system control mask wrong");

    skip_reserved_a: assert property (data_take && (off_reg == 8'h03 || off_reg == 8'h0D || off_reg == 8'h0F)
        |=> !ld_we_reg) else $error("reserved offset wrote a register");

    len_end_a: assert property (data_take && left_reg == 8'h01 && !reload
        |=> state_reg == S_DONE ##1 !ee_ready) else $error("block length not honoured");

endmodule

// ### include/erpm_cfg_if.sv
`timescale 1ns/100ps
interface erpm_cfg_if;
    logic ld_we;
    logic [7:0] ld_addr;
    logic [31:0] ld_data;
    logic [31:0] ld_mask;
    logic sw_we;
    logic [7:0] sw_addr;
    logic [31:0] sw_data;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic [3:0] status;

    modport ldr (output ld_we, ld_addr, ld_data, ld_mask, sw_we, sw_addr, sw_data, rd_addr, status,
                 input rd_data);
    modport regs (input ld_we, ld_addr, ld_data, ld_mask, sw_we, sw_addr, sw_data, rd_addr, status,
                  output rd_data);
endinterface

// ### include/erpm_pkg.sv
package erpm_pkg;

    // ==============================================================
    // register word addresses (byte addresses on the APB)
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_SSID = 8'h40;
    localparam logic [7:0] ADDR_LEGACY = 8'h44;
    localparam logic [7:0] ADDR_SYSCTL = 8'h80;
    localparam logic [7:0] ADDR_DEVCTL = 8'h90;
    localparam logic [7:0] ADDR_LDCTL = 8'hF0;
    localparam logic [7:0] ADDR_LDSTAT = 8'hF4;

    // ==============================================================
    // writable bits of each register
    localparam logic [31:0] MASK_CMD = 32'h00000167;
    localparam logic [31:0] MASK_SSID = 32'hFFFFFFFF;
    localparam logic [31:0] MASK_LEGACY = 32'hFFFFFFFE;
    localparam logic [31:0] MASK_SYSCTL = 32'h0000007F;
    localparam logic [31:0] MASK_DEVCTL = 32'h007E0000;

    // ==============================================================
    // values after reset
    localparam logic [31:0] RST_CMD = 32'h00000000;
    localparam logic [31:0] RST_SSID = 32'h00000000;
    localparam logic [31:0] RST_LEGACY = 32'h00000000;
    localparam logic [31:0] RST_SYSCTL = 32'h00000000;
    localparam logic [31:0] RST_DEVCTL = 32'h00000000;

    // ==============================================================
    // eeprom image offsets
    localparam logic [7:0] EE_CMD = 8'h02;
    localparam logic [7:0] EE_SSID_LO = 8'h04;
    localparam logic [7:0] EE_SSID_HI = 8'h07;
    localparam logic [7:0] EE_LEG_LO = 8'h08;
    localparam logic [7:0] EE_LEG_HI = 8'h0B;
    localparam logic [7:0] EE_SYSCTL = 8'h0C;
    localparam logic [7:0] EE_DEVCTL = 8'h17;
    localparam logic [7:0] EE_START = 8'h00;
    localparam logic [7:0] FUNC_CARD = 8'h00;

    // ==============================================================
    // loader control and status bits
    localparam int CTL_RELOAD_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ABORT_BIT = 2;
    localparam int ST_OTHERFN_BIT = 3;

    typedef enum logic [4:0] {
        S_IND = 5'b00001,
        S_LEN = 5'b00010,
        S_DATA = 5'b00100,
        S_DONE = 5'b01000,
        S_RESTART = 5'b10000
    } erpm_state_t;

    typedef struct packed {
        logic hit;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] mask;
    } erpm_wr_t;

    function automatic logic [31:0] erpm_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [31:0] mask);
        erpm_merge = (old & ~mask) | (nw & mask);
    endfunction

endpackage
